// file: dv/e3ri_fp_model.sv
// Receive frame processor stand-in: each kick bit changes the live input
// behind the latch of the same position (low half first, high half second).
`timescale 1ns/10ps
`default_nettype none
module e3ri_fp_model
(
  input  wire logic                         mclk,
  input  wire logic                         arst_n,
  input  wire logic [31:0]                  kick,
  output logic [3:0]                        timingSrcIndication,
  output logic [2:0]                        rxPayloadType,
  output logic                              ptypeUnstable,
  output logic                              ptypeMismatch,
  output logic                              unframedAllOnes,
  output logic [7:0]                        rxGenCommByte,
  output logic [7:0]                        rxNetReqByte,
  output logic                              alignLoad,
  output logic [e3ri_pkg::ALIGN_W-1:0]      alignPos,
  output logic                              frameLoss,
  output logic                              remoteDefect,
  output logic                              alarmInd,
  output logic                              outOfFrame,
  output logic                              rxSignalLossInput,
  output logic                              remoteErrEvent,
  output logic                              parityErrEvent,
  output logic                              framingErrEvent,
  output logic [e3ri_pkg::CNT_W-1:0]        remoteErrCount,
  output logic [e3ri_pkg::CNT_W-1:0]        parityErrCount,
  output logic [e3ri_pkg::CNT_W-1:0]        framingErrCount
);
  import e3ri_pkg::*;
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      {timingSrcIndication, rxPayloadType, ptypeUnstable, ptypeMismatch} <= '0;
      {unframedAllOnes, rxGenCommByte, rxNetReqByte, alignLoad, alignPos} <= '0;
      {frameLoss, remoteDefect, alarmInd, outOfFrame, rxSignalLossInput} <= '0;
      {remoteErrEvent, parityErrEvent, framingErrEvent} <= '0;
      {remoteErrCount, parityErrCount, framingErrCount} <= '0;
    end
    else
    begin
      timingSrcIndication <= timingSrcIndication + 4'(kick[13]);
      ptypeUnstable <= ptypeUnstable ^ kick[12];
      ptypeMismatch <= ptypeMismatch ^ kick[11];
      rxPayloadType <= rxPayloadType + 3'(kick[10]);
      unframedAllOnes <= unframedAllOnes ^ kick[8];
      rxGenCommByte <= rxGenCommByte + 8'(kick[7]);
      rxNetReqByte <= rxNetReqByte + 8'(kick[6]);
      alignLoad <= kick[5];
      alignPos <= alignPos + ALIGN_W'(kick[5]);
      {frameLoss, remoteDefect, alarmInd, outOfFrame, rxSignalLossInput} <=
        {frameLoss, remoteDefect, alarmInd, outOfFrame, rxSignalLossInput} ^ kick[4:0];
      {remoteErrEvent, parityErrEvent, framingErrEvent} <= kick[26:24];
      remoteErrCount <= remoteErrCount + CNT_W'(kick[18]);
      parityErrCount <= parityErrCount + CNT_W'(kick[17]);
      framingErrCount <= framingErrCount + CNT_W'(kick[16]);
    end
endmodule : e3ri_fp_model
`default_nettype wire

// file: dv/e3ri_sva.sv
// Port checker for the receive status latch and interrupt block.
// Assumes one clock domain with an active low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module e3ri_sva
(
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        globalPortStatusIrqEn,
  input wire logic        rxStatusIrq
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_idle: assert property (!psel |=> !pready)
    else $error("pready without select");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_rdata_upper: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
    else $error("upper read data not zero");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response malformed");
  a_irq_global: assert property (!globalPortStatusIrqEn |=> !rxStatusIrq)
    else $error("request while port disabled");
  a_irq_holds: assert property (rxStatusIrq && globalPortStatusIrqEn
    && !$past(psel && penable && pwrite) |=> rxStatusIrq)
    else $error("request dropped without clear");
  c_err: cover property (pready && pslverr);
  c_irq_up: cover property ($rose(rxStatusIrq));
  c_irq_down: cover property ($fell(rxStatusIrq));
endmodule : e3ri_sva
bind e3ri_top e3ri_sva chk_u (.*);
`default_nettype wire

// file: dv/e3ri_tb.sv
// Self-checking bench: APB master, frame processor stand-in and scenarios.
// Assumes the checker is bound into the block by its own file.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import e3ri_pkg::*;
  logic mclk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic globalPortStatusIrqEn = 1'b0, pready, pslverr, rxStatusIrq, alignLoad;
  logic [7:0] paddr = 8'h0, rxGenCommByte, rxNetReqByte;
  logic [31:0] pwdata = 32'h0, kick = 32'h0, prdata;
  logic [3:0] pstrb = 4'hf, timingSrcIndication;
  logic [2:0] rxPayloadType;
  logic ptypeUnstable, ptypeMismatch, unframedAllOnes, frameLoss, remoteDefect;
  logic alarmInd, outOfFrame, rxSignalLossInput;
  logic remoteErrEvent, parityErrEvent, framingErrEvent;
  logic [ALIGN_W-1:0] alignPos;
  logic [CNT_W-1:0] remoteErrCount, parityErrCount, framingErrCount;
  int n_fail = 0;
  int checks = 0;
  e3ri_top dut_u (.*);
  e3ri_fp_model fp_u (.*);
  always #50 mclk = ~mclk;
  // ****************************************
  // Shared tasks
  // ****************************************
  task finish_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd, output logic err);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (i == 20)
    begin
      n_fail++;
      finish_test();
    end
    // Answer taken at the same rising edge that shows pready high
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 32'h0, d, e);
    chk({d[31:1], d[0] | e}, exp);
  endtask : rd
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    logic e;
    apb(1'b1, a, v, d, e);
  endtask : wr
  task kickIt(input logic [31:0] v);
    @(posedge mclk);
    kick <= v;
    @(posedge mclk);
    kick <= 32'h0;
    repeat (5) @(negedge mclk);
  endtask : kickIt
  task irqIs(input logic v, input int n);
    repeat (n) @(negedge mclk);
    chk({31'h0, rxStatusIrq}, {31'h0, v});
  endtask : irqIs
  // ****************************************
  // Scenarios
  // ****************************************
  task t_regs;
    rd(8'hb0, 32'h0);
    rd(8'hb8, 32'h0);
    rd(8'ha0, 32'h0);
    rd(8'ha8, 32'h0);
    wr(8'hb0, 32'hffffffff);
    rd(8'hb0, {16'h0, LAT1_MASK});
    // Low lane only: upper byte of the enables must survive
    pstrb <= 4'h1;
    wr(8'hb0, 32'h0);
    rd(8'hb0, {16'h0, LAT1_MASK & 16'hff00});
    pstrb <= 4'hf;
    wr(8'hb0, 32'hffffffff);
    rd(8'hb0, {16'h0, LAT1_MASK});
    wr(8'hb8, 32'hffffffff);
    rd(8'hb8, {16'h0, LAT2_MASK});
    rd(8'hfc, 32'h1);
    kickIt(32'h20);
    rd(8'ha0, 32'h0);
  endtask : t_regs
  task t_sweep(input logic [7:0] a, input logic [15:0] m, input int sh);
    logic [15:0] b;
    for (int i = 0; i < 16; i++)
      if (m[i])
      begin
        b = 16'h1 << i;
        kickIt({16'h0, b} << sh);
        rd(a, {16'h0, b});
        irqIs(1'b1, 1);
        wr(a, {16'h0, b});
        rd(a, 32'h0);
        irqIs(1'b0, 2);
      end
  endtask : t_sweep
  task t_live;
    rd(8'h90, 32'h191f);
    rd(8'h98, 32'h7);
    rd(8'hc0, 32'h11);
    kickIt(32'h1900);
    rd(8'ha0, 32'h100);
    wr(8'ha0, 32'hffff);
    // Parity event lands on the clearing write's access edge
    fork
      wr(8'ha8, 32'h200);
      kickIt(32'h0200_0000);
    join
    rd(8'ha8, 32'h200);
    wr(8'ha8, 32'h200);
    rd(8'ha8, 32'h0);
  endtask : t_live
  task t_gate;
    kickIt(32'h1);
    wr(8'hb0, 32'h0);
    irqIs(1'b0, 3);
    wr(8'hb0, 32'h2);
    irqIs(1'b0, 3);
    wr(8'hb0, 32'h1);
    @(posedge mclk);
    globalPortStatusIrqEn <= 1'b0;
    irqIs(1'b0, 3);
    @(posedge mclk);
    globalPortStatusIrqEn <= 1'b1;
    irqIs(1'b1, 3);
  endtask : t_gate
  task t_reset;
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    irqIs(1'b0, 1);
    rd(8'hb0, 32'h0);
    rd(8'hb8, 32'h0);
    rd(8'ha0, 32'h0);
  endtask : t_reset
  initial
  begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    globalPortStatusIrqEn <= 1'b1;
    t_regs();
    t_sweep(8'ha0, LAT1_MASK, 0);
    t_sweep(8'ha8, LAT2_MASK, 16);
    t_live();
    t_gate();
    t_reset();
    finish_test();
  end
endmodule : testbench
`default_nettype wire

// file: src/e3ri_pkg.sv
// Constants for the E3 G.832 receive status latch and interrupt enable block.
// Assumes a 32-bit APB slave port and live status inputs synchronous to mclk.

package e3ri_pkg;

  localparam int unsigned PADDR_W = 8;
  localparam int unsigned ALIGN_W = 12;
  localparam int unsigned CNT_W   = 16;

  // Printed register indices; byte address is four times the index
  localparam logic [5:0] IDX_LIVE_1 = 6'h24;
  localparam logic [5:0] IDX_LIVE_2 = 6'h26;
  localparam logic [5:0] IDX_LAT_1  = 6'h28;
  localparam logic [5:0] IDX_LAT_2  = 6'h2a;
  localparam logic [5:0] IDX_IEN_1  = 6'h2c;
  localparam logic [5:0] IDX_IEN_2  = 6'h2e;
  localparam logic [5:0] IDX_MA     = 6'h30;

  // Implemented bits and reset values
  localparam logic [15:0] LAT1_MASK  = 16'h3dff;
  localparam logic [15:0] LAT2_MASK  = 16'h0707;
  localparam logic [15:0] IEN1_RESET = 16'h0000;
  localparam logic [15:0] IEN2_RESET = 16'h0000;
  localparam logic [15:0] LAT_RESET  = 16'h0000;

  // Field positions
  localparam int unsigned B_TS      = 13;
  localparam int unsigned B_PTU     = 12;
  localparam int unsigned B_PTM     = 11;
  localparam int unsigned B_PT      = 10;
  localparam int unsigned B_UA1     = 8;
  localparam int unsigned B_GC      = 7;
  localparam int unsigned B_NR      = 6;
  localparam int unsigned B_ALIGN   = 5;
  localparam int unsigned B_DEF_LO  = 0;
  localparam int unsigned B_EVT_LO  = 8;
  localparam int unsigned B_CNT_LO  = 0;
  localparam int unsigned B_MA_PT   = 4;

  typedef struct packed {
    logic [3:0]         prevTs;
    logic [2:0]         prevPt;
    logic               prevPtu;
    logic               prevPtm;
    logic               prevUa1;
    logic [4:0]         prevDef;
    logic [7:0]         prevGc;
    logic [7:0]         prevNr;
    logic [2:0]         prevNz;
    logic [ALIGN_W-1:0] alignPrev;
    logic               alignSeen;
    logic               primed;
    logic [15:0]        lat1;
    logic [15:0]        lat2;
    logic [15:0]        ien1;
    logic [15:0]        ien2;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic               irq;
  } e3ri_state_t;

endpackage : e3ri_pkg

// file: src/e3ri_top.sv
// Receive status latching, interrupt enables and request for one E3 port.
// Assumes live status and event inputs are synchronous to mclk and that
// the APB master keeps to the usual setup and access phases.

`timescale 1ns/10ps
`default_nettype none

module e3ri_top
(
  input  wire logic                          mclk,
  input  wire logic                          arst_n,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [e3ri_pkg::PADDR_W-1:0]  paddr,
  input  wire logic [31:0]                   pwdata,
  input  wire logic [3:0]                    pstrb,
  output var  logic [31:0]                   prdata,
  output var  logic                          pready,
  output var  logic                          pslverr,
  // Live status from the receive frame processor, port interrupt enable and request
  input  wire logic [3:0]                    timingSrcIndication,
  input  wire logic [2:0]                    rxPayloadType,
  input  wire logic                          ptypeUnstable,
  input  wire logic                          ptypeMismatch,
  input  wire logic                          unframedAllOnes,
  input  wire logic [7:0]                    rxGenCommByte,
  input  wire logic [7:0]                    rxNetReqByte,
  input  wire logic                          alignLoad,
  input  wire logic [e3ri_pkg::ALIGN_W-1:0]  alignPos,
  input  wire logic                          frameLoss,
  input  wire logic                          remoteDefect,
  input  wire logic                          alarmInd,
  input  wire logic                          outOfFrame,
  input  wire logic                          rxSignalLossInput,
  input  wire logic                          remoteErrEvent,
  input  wire logic                          parityErrEvent,
  input  wire logic                          framingErrEvent,
  input  wire logic [e3ri_pkg::CNT_W-1:0]    remoteErrCount,
  input  wire logic [e3ri_pkg::CNT_W-1:0]    parityErrCount,
  input  wire logic [e3ri_pkg::CNT_W-1:0]    framingErrCount,
  input  wire logic                          globalPortStatusIrqEn,
  output var  logic                          rxStatusIrq
);

  import e3ri_pkg::*;

  // ************************************************************
  // Decode
  // ************************************************************

  function automatic logic hitReg(input logic [PADDR_W-1:0] a,
                                  input logic [5:0] idx);
    hitReg = (a == {idx, 2'b00});
  endfunction : hitReg

  e3ri_state_t st_q;
  e3ri_state_t st_d;

  logic [4:0]  liveDef;
  logic [2:0]  liveNz;
  logic [15:0] live1;
  logic [15:0] live2;
  logic [15:0] maByte;
  logic [15:0] set1;
  logic [15:0] set2;
  logic [15:0] wMask;
  logic        setupRd;
  logic        accessWr;
  logic        mapped;

  // ************************************************************
  // Live status
  // ************************************************************

  assign liveDef = {frameLoss, remoteDefect, alarmInd, outOfFrame,
                    rxSignalLossInput};
  assign liveNz  = {remoteErrCount != '0, parityErrCount != '0,
                    framingErrCount != '0};

  always_comb
  begin
    live1 = 16'h0000;
    live1[B_PTU] = ptypeUnstable;
    live1[B_PTM] = ptypeMismatch;
    live1[B_UA1] = unframedAllOnes;
    live1[B_DEF_LO +: 5] = liveDef;
    live2 = 16'h0000;
    live2[B_CNT_LO +: 3] = liveNz;
    maByte = 16'h0000;
    maByte[B_MA_PT +: 3] = rxPayloadType;
    maByte[3:0] = timingSrcIndication;
  end

  // ************************************************************
  // Event detection
  // ************************************************************

  always_comb
  begin
    set1 = 16'h0000;
    set2 = 16'h0000;
    if (st_q.primed)
    begin
      set1[B_TS]  = timingSrcIndication != st_q.prevTs;
      set1[B_PTU] = ptypeUnstable & ~st_q.prevPtu;
      set1[B_PTM] = ptypeMismatch & ~st_q.prevPtm;
      set1[B_PT]  = rxPayloadType != st_q.prevPt;
      set1[B_UA1] = unframedAllOnes ^ st_q.prevUa1;
      set1[B_GC]  = rxGenCommByte != st_q.prevGc;
      set1[B_NR]  = rxNetReqByte != st_q.prevNr;
      set1[B_DEF_LO +: 5] = liveDef ^ st_q.prevDef;
      set2[B_CNT_LO +: 3] = liveNz & ~st_q.prevNz;
    end
    set1[B_ALIGN] = alignLoad & st_q.alignSeen &
                    (alignPos != st_q.alignPrev);
    set2[B_EVT_LO +: 3] = {remoteErrEvent, parityErrEvent,
                           framingErrEvent};
  end

  // ************************************************************
  // Register access
  // ************************************************************

  assign wMask    = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign setupRd  = psel & ~penable;
  assign accessWr = psel & penable & st_q.pready & pwrite & ~st_q.pslverr;
  assign mapped   = hitReg(paddr, IDX_LIVE_1) | hitReg(paddr, IDX_LIVE_2) |
                    hitReg(paddr, IDX_LAT_1)  | hitReg(paddr, IDX_LAT_2)  |
                    hitReg(paddr, IDX_IEN_1)  | hitReg(paddr, IDX_IEN_2)  |
                    hitReg(paddr, IDX_MA);

  always_comb
  begin
    logic [15:0] clr1;
    logic [15:0] clr2;
    logic [15:0] rd;
    clr1 = 16'h0000;
    clr2 = 16'h0000;
    rd   = 16'h0000;
    st_d = st_q;

    st_d.prevTs  = timingSrcIndication;
    st_d.prevPt  = rxPayloadType;
    st_d.prevPtu = ptypeUnstable;
    st_d.prevPtm = ptypeMismatch;
    st_d.prevUa1 = unframedAllOnes;
    st_d.prevDef = liveDef;
    st_d.prevGc  = rxGenCommByte;
    st_d.prevNr  = rxNetReqByte;
    st_d.prevNz  = liveNz;
    st_d.primed  = 1'b1;
    if (alignLoad)
    begin
      st_d.alignPrev = alignPos;
      st_d.alignSeen = 1'b1;
    end

    if (accessWr && hitReg(paddr, IDX_LAT_1))
      clr1 = pwdata[15:0] & wMask;
    if (accessWr && hitReg(paddr, IDX_LAT_2))
      clr2 = pwdata[15:0] & wMask;
    if (accessWr && hitReg(paddr, IDX_IEN_1))
      st_d.ien1 = ((st_q.ien1 & ~wMask) | (pwdata[15:0] & wMask))
                  & LAT1_MASK;
    if (accessWr && hitReg(paddr, IDX_IEN_2))
      st_d.ien2 = ((st_q.ien2 & ~wMask) | (pwdata[15:0] & wMask))
                  & LAT2_MASK;

    // Write-one-to-clear; a new event in the same cycle wins
    st_d.lat1 = ((st_q.lat1 & ~clr1) | set1) & LAT1_MASK;
    st_d.lat2 = ((st_q.lat2 & ~clr2) | set2) & LAT2_MASK;

    // One wait-free access phase: answer prepared during setup
    st_d.pready  = setupRd;
    st_d.pslverr = setupRd & ~mapped;
    if (setupRd && !pwrite)
    begin
      if (hitReg(paddr, IDX_LIVE_1))
        rd = live1;
      else if (hitReg(paddr, IDX_LIVE_2))
        rd = live2;
      else if (hitReg(paddr, IDX_LAT_1))
        rd = st_q.lat1;
      else if (hitReg(paddr, IDX_LAT_2))
        rd = st_q.lat2;
      else if (hitReg(paddr, IDX_IEN_1))
        rd = st_q.ien1;
      else if (hitReg(paddr, IDX_IEN_2))
        rd = st_q.ien2;
      else if (hitReg(paddr, IDX_MA))
        rd = maByte;
      st_d.prdata = {16'h0000, rd};
    end
    else if (setupRd)
      st_d.prdata = 32'h0000_0000;

    st_d.irq = globalPortStatusIrqEn &
               (|(st_q.lat1 & st_q.ien1) |
                |(st_q.lat2 & st_q.ien2));
  end

  // ************************************************************
  // State register
  // ************************************************************

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q      <= '0;
      st_q.lat1 <= LAT_RESET;
      st_q.lat2 <= LAT_RESET;
      st_q.ien1 <= IEN1_RESET;
      st_q.ien2 <= IEN2_RESET;
    end
    else
      st_q <= st_d;
  end

  assign prdata      = st_q.prdata;
  assign pready      = st_q.pready;
  assign pslverr     = st_q.pslverr;
  assign rxStatusIrq = st_q.irq;

endmodule : e3ri_top

`default_nettype wire
